/* File: src/adc_core.sv */
// Conversion sequencer and five-wire slave serial port of a 10-bit ADC.
// Assumes host drives serial clock, select and direction; conversion data
// arrives from the analog core as a parallel word sampled at end of conversion.
`timescale 1ns/10ps
// How it works
// - Falling start edge begins a conversion and puts track-and-hold into hold.
// - Busy high during conversion: 9 us analog, 27 us temperature channel.
// - Start released before busy falls keeps the device powered afterwards.
// - Start still low when busy falls powers the device down.
// - Rising start edge powers a powered-down device back up.
// - Serial port is slave only; host supplies every serial clock.
// - Control writes on serial input, results on separate serial output.
// - Direction line low means write, high means read.
// - Rising direction line drives result MSB onto serial output.
// - Later bits shift on falling serial clock, first falling edge skipped.
// - A read carries ten bits; host may stop after eight.
// - Output goes high impedance on select rising or direction falling.
// - Reading erases the result until another conversion completes.
// - Write captures control byte on first eight rising clocks only.
// - Channel code 000 selects the temperature sensor.
module adc_core
  import adc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_wr,
  input wire logic sclk,
  input wire logic din,
  input wire logic [RESULT_W-1:0] sample_data,
  output logic busy,
  output logic hold,
  output logic powered,
  output logic [2:0] channel,
  output logic dout_o,
  output logic dout_oe_n,
  output logic result_valid
);
  pin_events_if ev();

  pin_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pins({1'b0, din, sclk, rd_wr, cs_n, conversion_start_n}),
    .ev(ev)
  );

  function automatic logic [CNT_W-1:0] conv_len(input logic [2:0] chan);
    conv_len = (chan == CHAN_TEMP) ? CNT_W'(CONV_TEMP_CYC - 1) :
      CNT_W'(CONV_ANALOG_CYC - 1);
  endfunction

  // Conversion sequencer
  conv_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic powered_reg, powered_next;
  logic eoc;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    powered_next = powered_reg;
    eoc = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (ev.conv_fall) begin
          state_next = ST_CONV;
          cnt_next = conv_len(channel);
        end
      end
      ST_CONV: begin
        if (cnt_reg == '0) begin
          eoc = 1'b1;
          if (!ev.conv_n_lvl) begin
            state_next = ST_DOWN;
            powered_next = 1'b0;
          end else begin
            state_next = ST_IDLE;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_DOWN: begin
        if (ev.conv_rise) begin
          state_next = ST_IDLE;
          powered_next = 1'b1;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      powered_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      powered_reg <= powered_next;
    end
  end

  assign busy = (state_reg == ST_CONV);
  assign hold = (state_reg == ST_CONV);
  assign powered = powered_reg;

  // Serial port, slave only: every shift is caused by a host clock edge
  logic [RESULT_W-1:0] shift_reg, shift_next;
  logic valid_reg, valid_next;
  logic [BITCNT_W-1:0] rbits_reg, rbits_next;
  logic first_fall_reg, first_fall_next;
  logic drive_reg, drive_next;
  logic dout_reg, dout_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [BITCNT_W-1:0] wbits_reg, wbits_next;
  logic selected;

  assign selected = ~ev.cs_n_lvl;

  always_comb begin
    shift_next = shift_reg;
    valid_next = valid_reg;
    rbits_next = rbits_reg;
    first_fall_next = first_fall_reg;
    drive_next = drive_reg;
    dout_next = dout_reg;
    ctrl_next = ctrl_reg;
    wbits_next = wbits_reg;
    if (ev.rd_rise && selected) begin
      // A new read starts only after a low-then-high on the direction line
      drive_next = 1'b1;
      dout_next = valid_reg ? shift_reg[RESULT_W-1] : 1'b0;
      rbits_next = BITCNT_W'(1);
      first_fall_next = 1'b1;
      // Erasing at read start: the copy in the shifter is what gets sent
      valid_next = 1'b0;
    end else if (drive_reg && ev.sclk_fall && ev.rd_lvl) begin
      if (first_fall_reg) begin
        first_fall_next = 1'b0;
      end else if (rbits_reg < BITCNT_W'(RESULT_W)) begin
        shift_next = {shift_reg[RESULT_W-2:0], 1'b0};
        dout_next = shift_reg[RESULT_W-2] & (|shift_reg);
        rbits_next = rbits_reg + 1'b1;
      end
    end
    if (drive_reg && (ev.cs_rise || ev.rd_fall)) begin
      drive_next = 1'b0;
      shift_next = RESULT_RESET;
    end
    if (ev.rd_fall) begin
      wbits_next = '0;
    end
    if (!ev.rd_lvl && selected && ev.sclk_rise && wbits_reg < BITCNT_W'(CTRL_W)) begin
      ctrl_next = {ctrl_reg[CTRL_W-2:0], ev.din_lvl};
      wbits_next = wbits_reg + 1'b1;
    end
    if (eoc) begin
      // A completed conversion wins over an erase in the same cycle
      shift_next = sample_data;
      valid_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg <= RESULT_RESET;
      valid_reg <= 1'b0;
      rbits_reg <= '0;
      first_fall_reg <= 1'b0;
      drive_reg <= 1'b0;
      dout_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      wbits_reg <= '0;
    end else begin
      shift_reg <= shift_next;
      valid_reg <= valid_next;
      rbits_reg <= rbits_next;
      first_fall_reg <= first_fall_next;
      drive_reg <= drive_next;
      dout_reg <= dout_next;
      ctrl_reg <= ctrl_next;
      wbits_reg <= wbits_next;
    end
  end

  assign channel = ctrl_reg[CHAN_HI:CHAN_LO];
  assign dout_o = dout_reg;
  assign dout_oe_n = ~drive_reg;
  assign result_valid = valid_reg;
endmodule

/* File: src/adc_pkg.sv */
// Constants for the conversion sequencer and serial readout.
// Assumes a 10 MHz system clock; all pins are asynchronous to it.
package adc_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CONV_ANALOG_US = 9;
  localparam int CONV_TEMP_US = 27;
  localparam int CONV_ANALOG_CYC = (CONV_ANALOG_US * CLK_HZ) / 1_000_000;
  localparam int CONV_TEMP_CYC = (CONV_TEMP_US * CLK_HZ) / 1_000_000;
  localparam int CNT_W = 10;
  localparam int RESULT_W = 10;
  localparam int CTRL_W = 8;
  localparam int BITCNT_W = 4;
  // Channel field sits in the top three bits of the control byte
  localparam int CHAN_HI = 7;
  localparam int CHAN_LO = 5;
  localparam logic [2:0] CHAN_TEMP = 3'h0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  typedef enum {ST_IDLE, ST_CONV, ST_DOWN} conv_state_t;
endpackage

/* File: src/pin_events_if.sv */
// Synchronised pin levels and edge pulses passed to the sequencer and serial port.
// Assumes one producer (the pin synchroniser) and one consumer.
`timescale 1ns/10ps
interface pin_events_if;
  logic conv_n_lvl;
  logic conv_fall;
  logic conv_rise;
  logic cs_n_lvl;
  logic cs_rise;
  logic rd_lvl;
  logic rd_rise;
  logic rd_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic din_lvl;
  modport sync (output conv_n_lvl, conv_fall, conv_rise, cs_n_lvl, cs_rise,
    rd_lvl, rd_rise, rd_fall, sclk_rise, sclk_fall, din_lvl);
  modport core (input conv_n_lvl, conv_fall, conv_rise, cs_n_lvl, cs_rise,
    rd_lvl, rd_rise, rd_fall, sclk_rise, sclk_fall, din_lvl);
endinterface

/* File: src/pin_sync.sv */
// Three-flop synchroniser with edge detection for the external pins.
// Assumes pins are asynchronous to clk; an edge counts when stages 2 and 3 differ.
`timescale 1ns/10ps
module pin_sync
  import adc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] pins,
  pin_events_if.sync ev
);
  // Bit order: 0 conv_n, 1 cs_n, 2 rd, 3 sclk, 4 din
  logic [5:0] s1_reg, s2_reg, s3_reg;
  logic [5:0] s1_next, s2_next, s3_next;

  always_comb begin
    s1_next = pins;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle levels: start high, select high, read low, clock high, data high.
      // Matching the idle pins keeps a false edge from appearing after reset.
      s1_reg <= 6'h1B;
      s2_reg <= 6'h1B;
      s3_reg <= 6'h1B;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign ev.conv_n_lvl = s3_reg[0];
  assign ev.conv_fall = s3_reg[0] & ~s2_reg[0];
  assign ev.conv_rise = ~s3_reg[0] & s2_reg[0];
  assign ev.cs_n_lvl = s3_reg[1];
  assign ev.cs_rise = ~s3_reg[1] & s2_reg[1];
  assign ev.rd_lvl = s3_reg[2];
  assign ev.rd_rise = ~s3_reg[2] & s2_reg[2];
  assign ev.rd_fall = s3_reg[2] & ~s2_reg[2];
  assign ev.sclk_rise = ~s3_reg[3] & s2_reg[3];
  assign ev.sclk_fall = s3_reg[3] & ~s2_reg[3];
  assign ev.din_lvl = s2_reg[4];
endmodule

/* File: bench/adc_core_sva.sv */
// Port checker for adc_core.
// Assumes pins reach the core through a few clocks of synchroniser lag.
`timescale 1ns/10ps
module adc_core_sva
  import adc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conversion_start_n,
  input wire logic cs_n,
  input wire logic rd_wr,
  input wire logic [RESULT_W-1:0] sample_data,
  input wire logic busy,
  input wire logic hold,
  input wire logic powered,
  input wire logic [2:0] channel,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic result_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Busy length, channel and result of the latest conversion
  int len_reg;
  logic [2:0] chan_reg;
  logic [RESULT_W-1:0] res_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      len_reg <= 0;
      chan_reg <= 3'h0;
      res_reg <= 10'h000;
    end else begin
      len_reg <= busy ? len_reg + 1 : 0;
      if ($rose(busy)) chan_reg <= channel;
      if ($fell(busy)) res_reg <= sample_data;
    end
  end
  property p_start; $fell(conversion_start_n) && !busy && powered |-> ##[2:6] busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_hold; $fell(conversion_start_n) && !busy && powered |-> ##[2:6] hold; endproperty
  a_hold: assert property (p_hold) else $error("not in hold");
  property p_len;
    $fell(busy) |-> len_reg == (chan_reg == CHAN_TEMP ? CONV_TEMP_CYC : CONV_ANALOG_CYC);
  endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_rv; $fell(busy) |-> result_valid; endproperty
  a_rv: assert property (p_rv) else $error("no result");
  property p_pd; $fell(busy) && $past(conversion_start_n, 8) == 1'b0 && !conversion_start_n |-> !powered; endproperty
  a_pd: assert property (p_pd) else $error("no power down");
  property p_keep; $fell(busy) && $past(conversion_start_n, 8) && conversion_start_n |-> powered; endproperty
  a_keep: assert property (p_keep) else $error("lost power");
  property p_wake; !powered && $rose(conversion_start_n) |-> ##[2:6] powered; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_msb; $fell(dout_oe_n) && $past(result_valid, 2) |-> dout_o == res_reg[RESULT_W-1]; endproperty
  a_msb: assert property (p_msb) else $error("bad first bit");
  property p_zero; $fell(dout_oe_n) && !$past(result_valid, 2) |-> !dout_o; endproperty
  a_zero: assert property (p_zero) else $error("stale data");
  property p_hiz; $rose(cs_n) || $fell(rd_wr) |-> ##[1:6] dout_oe_n; endproperty
  a_hiz: assert property (p_hiz) else $error("output not released");
  c_temp: cover property ($fell(busy) && chan_reg == CHAN_TEMP);
  c_down: cover property (!powered);
  c_read: cover property ($fell(dout_oe_n));
endmodule
bind adc_core adc_core_sva chk_i (.clk, .reset_n, .conversion_start_n, .cs_n, .rd_wr,
  .sample_data, .busy, .hold, .powered, .channel, .dout_o, .dout_oe_n, .result_valid);

/* File: bench/host_model.sv */
// Host model: start pulse, select, direction, serial clock and data.
// Assumes a 100 ns clk; serial clock is 800 ns and idles high.
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  input wire logic busy,
  input wire logic dout_line,
  output logic conversion_start_n,
  output logic cs_n,
  output logic rd_wr,
  output logic sclk,
  output logic din
);
  initial begin
    conversion_start_n = 1'b1;
    cs_n = 1'b1;
    rd_wr = 1'b0;
    sclk = 1'b1;
    din = 1'b1;
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Returns busy length in cycles; mode2 keeps start low past the end
  task automatic conv(input bit mode2, output int len);
    len = 0;
    conversion_start_n = 1'b0;
    for (int i = 0; i < 400; i++) begin
      tick(1);
      if (busy) len++;
      if (i == 20 && !mode2) conversion_start_n = 1'b1;
      if (!busy && len > 0) break;
    end
  endtask
  task automatic wake;
    conversion_start_n = 1'b1;
    tick(10);
  endtask
  task automatic rd(input int nb, input bit drop_cs, output logic [9:0] got);
    got = 10'h000;
    cs_n = 1'b0;
    tick(2);
    rd_wr = 1'b1;
    tick(8);
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b0;
      tick(4);
      sclk = 1'b1;
      tick(4);
      got[9 - i] = dout_line;
    end
    if (drop_cs) cs_n = 1'b1;
    else rd_wr = 1'b0;
    tick(8);
    cs_n = 1'b1;
    rd_wr = 1'b0;
    tick(2);
  endtask
  // Two extra clocks with toggled data must not reach the control byte
  task automatic wr(input logic [7:0] b);
    rd_wr = 1'b1;
    tick(8);
    rd_wr = 1'b0;
    cs_n = 1'b0;
    tick(8);
    for (int i = 0; i < 10; i++) begin
      sclk = 1'b0;
      din = (i < 8) ? b[3'(7 - i)] : ~din;
      tick(4);
      sclk = 1'b1;
      tick(4);
    end
    din = ~din;
    cs_n = 1'b1;
    tick(8);
  endtask
endmodule

/* File: bench/adc_core_tb.sv */
// Testbench for adc_core with the host model on its pins.
// Assumes the checker is bound to the core by its own file.
`timescale 1ns/10ps
module adc_core_tb
  import adc_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [RESULT_W-1:0] sample_data = 10'h2A5;
  wire conversion_start_n, cs_n, rd_wr, sclk, din;
  wire busy, hold, powered, dout_o, dout_oe_n, result_valid;
  wire [2:0] channel;
  wire dout_line = !dout_oe_n ? dout_o : 1'bz;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  adc_core dut (.clk(clk), .reset_n(reset_n), .conversion_start_n(conversion_start_n),
    .cs_n(cs_n), .rd_wr(rd_wr), .sclk(sclk), .din(din), .sample_data(sample_data),
    .busy(busy), .hold(hold), .powered(powered), .channel(channel), .dout_o(dout_o),
    .dout_oe_n(dout_oe_n), .result_valid(result_valid));
  host_model host (.clk(clk), .busy(busy), .dout_line(dout_line),
    .conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_wr(rd_wr), .sclk(sclk),
    .din(din));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_analog;
    int len;
    logic [9:0] got;
    host.wr(8'hA0);
    chk({7'h0, channel}, 10'h005);
    host.conv(1'b0, len);
    chk(10'(len), 10'(CONV_ANALOG_CYC));
    chk({9'h0, powered}, 10'h001);
    chk({9'h0, result_valid}, 10'h001);
    host.rd(10, 1'b0, got);
    chk(got, 10'h2A5);
    chk({9'h0, result_valid}, 10'h000);
    chk({9'h0, dout_oe_n}, 10'h001);
    host.rd(10, 1'b0, got);
    chk(got, 10'h000);
    $display("t_analog done");
  endtask
  task automatic t_temp;
    int len;
    logic [9:0] got;
    sample_data = 10'h15A;
    host.wr(8'h1F);
    chk({7'h0, channel}, 10'h000);
    host.conv(1'b1, len);
    chk(10'(len), 10'(CONV_TEMP_CYC));
    chk({9'h0, powered}, 10'h000);
    host.wake();
    chk({9'h0, powered}, 10'h001);
    host.rd(8, 1'b1, got);
    chk(got, 10'h158);
    chk({9'h0, dout_oe_n}, 10'h001);
    $display("t_temp done");
  endtask
  task automatic summarize;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_analog();
    t_temp();
    summarize();
  end
endmodule
